// >>> design/flash_pkg.sv
package flash_pkg;

   ////////////////////////////////////////////////////////////////////////
   // instruction opcodes
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_OTP_ENTER = 8'h3A;
   localparam logic [7:0] OP_WHOLE_WIPE = 8'hC7;

   ////////////////////////////////////////////////////////////////////////
   // status byte layout
   localparam int BUSY_POS = 0;
   localparam int WEL_POS = 1;
   localparam int BP_LSB = 2;
   localparam int BP_W = 3;
   localparam int LOCK_POS = 7;
   localparam logic [1:0] RSVD_VAL = 2'h0;
   localparam logic [BP_W-1:0] BP_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // frame geometry, counted in whole bytes after select falls
   localparam int ADDR_W = 24;
   localparam logic [2:0] NB_OPCODE = 3'h1;
   localparam logic [2:0] NB_WRITE_STATUS_INSTR = 3'h2;
   localparam logic [2:0] NB_LAST_ADDR = 3'h3;
   localparam logic [2:0] NB_FAST_DUMMY = 3'h4;
   localparam logic [2:0] NB_PP_MIN = 3'h5;
   localparam logic [2:0] NB_SAT = 3'h7;
   localparam int PAGE_BYTES = 256;
   localparam logic [7:0] ERASED = 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // self-timed cycle lengths
   localparam int CLK_NS = 100;
   localparam int T_WRITE_STATUS_INSTR_NS = 10000;
   localparam int T_PP_NS = 15000;
   localparam int T_WIPE_NS = 50000;
   localparam int TIMER_W = 16;
   localparam logic [15:0] WRITE_STATUS_INSTR_CYC = 16'((T_WRITE_STATUS_INSTR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] PP_CYC = 16'((T_PP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] WIPE_CYC = 16'((T_WIPE_NS + CLK_NS - 1) / CLK_NS);

   // kind of self-timed cycle in flight
   typedef enum logic [1:0] {
      CYC_WRITE_STATUS_INSTR = 2'b00,
      CYC_PAGE = 2'b01,
      CYC_WIPE = 2'b11
   } cyc_t;

endpackage

// >>> design/bit_sync.sv
`timescale 1ns/1ns
module bit_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   // first stage feeds only the second stage
   always_comb begin
      s_d = s_q;
      s_d.meta = d;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;

endmodule

// >>> design/cycle_timer.sv
`timescale 1ns/1ns
module cycle_timer #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [W-1:0] count,
   output logic busy,
   output logic done
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic busy;
   } tmr_t;

   tmr_t t_q;
   tmr_t t_d;

   // busy for exactly count cycles after start
   always_comb begin
      t_d = t_q;
      if (start) begin
         t_d.cnt = count;
         t_d.busy = 1'b1;
      end else if (t_q.busy) begin
         t_d.cnt = t_q.cnt - W'(1);
         if (t_q.cnt <= W'(1)) begin
            t_d.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         t_q <= '0;
      end else begin
         t_q <= t_d;
      end
   end

   assign busy = t_q.busy;
   assign done = t_q.busy & (t_q.cnt <= W'(1)) & ~start;

endmodule

// >>> design/flash_status_seq.sv
// Summary of operation
// - status readable anytime, repeats until deselect
// - busy_flag high during write, program, erase
// - latch clear refuses status-write, program, erase
// - protect bits set only by status-write
// - whole wipe only with protect bits zero
// - status bits five and six read zero
// - status-write keeps bits 6,5,1,0
// - lock bit plus guard low blocks status-write, except in one-time mode
// - sealed one-time area refuses program, erase
// - one-time mode status-write just seals
// - status-write needs opcode plus exactly one byte
// - status-write timed cycle, then latch clears
// - plain read: opcode, address, then data
// - fast read adds one dummy byte
// - read address increments and wraps to zero
// - deselect ends a read at once
// - reads refused while a cycle runs
// - page write: opcode, address, data bytes
// - page data wraps within its page
// - last 256 bytes win, others untouched
// - page write on byte boundary, timed cycle
// - protected page never programmed outside one-time mode
// - write-unlock opcode sets the latch
// - all fields travel msb first
`timescale 1ns/1ns
module flash_status_seq #(
   parameter int ARR_AW = 12
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in,
   input wire logic wp_n,
   output logic serial_out,
   output logic serial_out_oe
);

   ////////////////////////////////////////////////////////////////////////
   // state types

   // link side, clocked by the serial clock
   typedef struct packed {
      logic [2:0] bit_idx;
      logic [2:0] nbytes;
      logic [6:0] sh;
      logic [7:0] op;
      logic [23:0] addr;
      logic [7:0] wdat;
      logic [23:0] rd_addr;
      logic [7:0] obyte;
      logic oen;
      logic [7:0] pidx;
      logic [255:0] pmask;
      logic [255:0][7:0] pb;
      logic tog;
   } link_t;

   // falling-edge output stage
   typedef struct packed {
      logic so;
      logic oe;
   } out_t;

   // core side, clocked by clk_sys
   typedef struct packed {
      logic write_latch_flag;
      logic [2:0] bp;
      logic lock;
      logic otp;
      logic tog_seen;
      logic cs_prev;
      logic [7:0] wdat;
      flash_pkg::cyc_t kind;
      logic [(1<<ARR_AW)-1:0][7:0] mem;
   } sys_t;

   link_t lk_q;
   link_t lk_d;
   out_t out_q;
   logic frame_q;
   sys_t sy_q;
   sys_t sy_d;

   logic [7:0] stat_l;
   logic [7:0] status;
   logic [2:0] sys_in;
   logic cs_s;
   logic tog_s;
   logic wp_s;
   logic busy;
   logic done;
   logic start;
   logic [15:0] cyc_cnt;

   ////////////////////////////////////////////////////////////////////////
   // status byte as seen by the host

   // busy, latch, protect level, reserved zero, lock
   assign status = {sy_q.lock, flash_pkg::RSVD_VAL, sy_q.bp, sy_q.write_latch_flag,
                    busy};

   ////////////////////////////////////////////////////////////////////////
   // link side

   // status crosses bit by bit; it moves between frames or when a timed cycle ends
   bit_sync #(
      .W(8),
      .RST_VAL(8'h00)
   ) u_stat_sync (
      .clk(sclk),
      .rst(1'b0),
      .d(status),
      .q(stat_l)
   );

   // marks that at least one clock edge belongs to this frame
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         frame_q <= 1'b0;
      end else begin
         frame_q <= 1'b1;
      end
   end

   // shift in, decode fields, pick the next output byte
   always_comb begin
      logic first;
      logic [2:0] b;
      logic [2:0] nb;
      logic [7:0] byte_in;
      logic [7:0] opn;
      logic [23:0] new_addr;
      logic [23:0] at;
      logic rd_go;
      logic rd_start;
      first = ~frame_q;
      b = first ? 3'h0 : lk_q.bit_idx;
      nb = first ? 3'h0 : lk_q.nbytes;
      byte_in = {lk_q.sh, serial_in};
      opn = (nb == 3'h0) ? byte_in : lk_q.op;
      new_addr = {lk_q.addr[15:0], byte_in};
      at = (nb == flash_pkg::NB_LAST_ADDR) ? new_addr : lk_q.rd_addr;
      rd_go = ((opn == flash_pkg::OP_READ) &&
               (nb >= flash_pkg::NB_LAST_ADDR)) ||
              ((opn == flash_pkg::OP_FAST_READ) &&
               (nb >= flash_pkg::NB_FAST_DUMMY));
      rd_start = ((opn == flash_pkg::OP_READ) &&
                  (nb == flash_pkg::NB_LAST_ADDR)) ||
                 ((opn == flash_pkg::OP_FAST_READ) &&
                  (nb == flash_pkg::NB_FAST_DUMMY));
      lk_d = lk_q;
      lk_d.nbytes = nb;
      if (first) begin
         // new frame: forget last frame's page data and output
         lk_d.tog = ~lk_q.tog;
         lk_d.pmask = '0;
         lk_d.oen = 1'b0;
      end
      lk_d.sh = {lk_q.sh[5:0], serial_in};
      lk_d.bit_idx = b + 3'h1;
      if (b == 3'h7) begin
         if (nb != flash_pkg::NB_SAT) begin
            lk_d.nbytes = nb + 3'h1;
         end
         if (nb == 3'h0) begin
            lk_d.op = byte_in;
         end
         if (nb == 3'h1) begin
            lk_d.wdat = byte_in;
         end
         if ((nb >= 3'h1) && (nb <= flash_pkg::NB_LAST_ADDR)) begin
            lk_d.addr = new_addr;
         end
         if (nb == flash_pkg::NB_LAST_ADDR) begin
            lk_d.pidx = byte_in;
            lk_d.rd_addr = new_addr;
         end
         // page data wraps in the page, later bytes overwrite
         if ((nb > flash_pkg::NB_LAST_ADDR) &&
             (opn == flash_pkg::OP_PAGE_WRITE)) begin
            lk_d.pb[lk_q.pidx] = byte_in;
            lk_d.pmask[lk_q.pidx] = 1'b1;
            lk_d.pidx = lk_q.pidx + 8'h01;
         end
         // status repeats for as long as the frame lasts
         if (opn == flash_pkg::OP_READ_STATUS) begin
            lk_d.obyte = stat_l;
            lk_d.oen = 1'b1;
         end else if (rd_go) begin
            lk_d.obyte = sy_q.mem[at[ARR_AW-1:0]];
            lk_d.rd_addr = at + 24'h00_0001;
            if (rd_start) begin
               lk_d.oen = ~stat_l[flash_pkg::BUSY_POS];
            end
         end
      end
   end

   // link state; core reset clears it while the link clock is idle,
   // so the frame toggle starts from a known level
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // data leaves on the falling edge, msb first; deselect stops it
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         out_q <= '0;
      end else begin
         out_q.so <= lk_q.obyte[~lk_q.bit_idx];
         out_q.oe <= lk_q.oen & frame_q;
      end
   end

   assign serial_out = out_q.so;
   assign serial_out_oe = out_q.oe & ~cs_n;

   ////////////////////////////////////////////////////////////////////////
   // core side

   // select, frame toggle and guard pin into the core clock
   bit_sync #(
      .W(3),
      .RST_VAL(3'h5)
   ) u_sys_sync (
      .clk(clk_sys),
      .rst(rst),
      .d({cs_n, lk_q.tog, wp_n}),
      .q(sys_in)
   );

   assign cs_s = sys_in[2];
   assign tog_s = sys_in[1];
   assign wp_s = sys_in[0];

   // self-timed program, wipe and status-write cycles
   cycle_timer #(
      .W(flash_pkg::TIMER_W)
   ) u_timer (
      .clk(clk_sys),
      .rst(rst),
      .start(start),
      .count(cyc_cnt),
      .busy(busy),
      .done(done)
   );

   // decode a finished frame once select has settled high
   always_comb begin
      logic cs_rise;
      logic whole;
      logic hw_lock;
      logic prot;
      logic [ARR_AW-9:0] page;
      sy_d = sy_q;
      start = 1'b0;
      cyc_cnt = '0;
      cs_rise = cs_s & ~sy_q.cs_prev;
      whole = lk_q.bit_idx == 3'h0;
      hw_lock = sy_q.lock & ~wp_s;
      prot = (sy_q.bp != flash_pkg::BP_RST) &&
             (({1'b0, lk_q.addr[23:21]} + {1'b0, sy_q.bp}) >= 4'h8);
      page = lk_q.addr[ARR_AW-1:8];
      sy_d.cs_prev = cs_s;
      if (cs_rise && (tog_s != sy_q.tog_seen)) begin
         sy_d.tog_seen = tog_s;
         if (!busy && whole) begin
            unique case (lk_q.op)
               flash_pkg::OP_WRITE_UNLOCK: begin
                  if (lk_q.nbytes == flash_pkg::NB_OPCODE) begin
                     sy_d.write_latch_flag = 1'b1;
                  end
               end
               flash_pkg::OP_WRITE_LOCK: begin
                  if (lk_q.nbytes == flash_pkg::NB_OPCODE) begin
                     sy_d.write_latch_flag = 1'b0;
                     sy_d.otp = 1'b0;
                  end
               end
               flash_pkg::OP_OTP_ENTER: begin
                  if (lk_q.nbytes == flash_pkg::NB_OPCODE) begin
                     sy_d.otp = 1'b1;
                  end
               end
               flash_pkg::OP_WRITE_STATUS: begin
                  if ((lk_q.nbytes == flash_pkg::NB_WRITE_STATUS_INSTR) && sy_q.write_latch_flag &&
                      (sy_q.otp || !hw_lock)) begin
                     start = 1'b1;
                     cyc_cnt = flash_pkg::WRITE_STATUS_INSTR_CYC;
                     sy_d.kind = flash_pkg::CYC_WRITE_STATUS_INSTR;
                     // one-time mode ignores the data and seals
                     sy_d.wdat = sy_q.otp ?
                        {1'b1, 2'h0, sy_q.bp, 2'h0} : lk_q.wdat;
                  end
               end
               flash_pkg::OP_PAGE_WRITE: begin
                  if ((lk_q.nbytes >= flash_pkg::NB_PP_MIN) && sy_q.write_latch_flag &&
                      (sy_q.otp ? !sy_q.lock : !prot)) begin
                     start = 1'b1;
                     cyc_cnt = flash_pkg::PP_CYC;
                     sy_d.kind = flash_pkg::CYC_PAGE;
                     sy_d.write_latch_flag = 1'b0;
                     // only bytes that arrived are written
                     for (int i = 0; i < flash_pkg::PAGE_BYTES; i++) begin
                        if (lk_q.pmask[i]) begin
                           sy_d.mem[{page, 8'(i)}] = lk_q.pb[i];
                        end
                     end
                  end
               end
               flash_pkg::OP_WHOLE_WIPE: begin
                  if ((lk_q.nbytes == flash_pkg::NB_OPCODE) && sy_q.write_latch_flag &&
                      (sy_q.bp == flash_pkg::BP_RST) &&
                      !(sy_q.otp && sy_q.lock)) begin
                     start = 1'b1;
                     cyc_cnt = flash_pkg::WIPE_CYC;
                     sy_d.kind = flash_pkg::CYC_WIPE;
                     sy_d.write_latch_flag = 1'b0;
                     sy_d.mem = {(1 << ARR_AW){flash_pkg::ERASED}};
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // status-write lands when its timed cycle ends
      if (done) begin
         sy_d.write_latch_flag = 1'b0;
         if (sy_q.kind == flash_pkg::CYC_WRITE_STATUS_INSTR) begin
            sy_d.bp = sy_q.wdat[flash_pkg::BP_LSB +: flash_pkg::BP_W];
            sy_d.lock = sy_q.wdat[flash_pkg::LOCK_POS] |
                        (sy_q.otp & sy_q.lock);
         end
      end
   end

   // protect and lock bits start clear, array starts erased
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sy_q <= '0;
         sy_q.bp <= flash_pkg::BP_RST;
         sy_q.cs_prev <= 1'b1;
         sy_q.kind <= flash_pkg::CYC_WRITE_STATUS_INSTR;
         sy_q.mem <= {(1 << ARR_AW){flash_pkg::ERASED}};
      end else begin
         sy_q <= sy_d;
      end
   end

endmodule

// >>> bench/flash_status_seq_props.sv
`timescale 1ns/1ns
module flash_status_seq_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in,
   input wire logic wp_n,
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   logic [11:0] cnt_q;
   logic [7:0] op_q;
   // rising edges and opcode of the frame
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_q <= '0;
         op_q <= '0;
      end else begin
         if (cnt_q != 12'h0FFF) begin
            cnt_q <= cnt_q + 12'h0001;
         end
         if (cnt_q < 12'h0008) begin
            op_q <= {op_q[6:0], serial_in};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   property p_idle;
      @(posedge clk_sys) disable iff (rst)
         cs_n |-> !serial_out_oe && !serial_out;
   endproperty
   a_idle: assert property (p_idle) else $error("drive while idle");
   property p_hdr;
      @(posedge sclk) disable iff (cs_n) cnt_q < 12'h0008 |-> !serial_out_oe;
   endproperty
   a_hdr: assert property (p_hdr) else $error("drive in opcode");
   property p_stat;
      @(posedge sclk) disable iff (cs_n)
         cnt_q >= 12'h0008 && op_q == flash_pkg::OP_READ_STATUS
         |-> serial_out_oe;
   endproperty
   a_stat: assert property (p_stat) else $error("status not driven");
   property p_rsvd;
      @(posedge sclk) disable iff (cs_n)
         cnt_q >= 12'h0008 && op_q == flash_pkg::OP_READ_STATUS &&
         cnt_q[2:0] inside {3'h1, 3'h2} |-> !serial_out;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_quiet;
      @(posedge sclk) disable iff (cs_n)
         op_q inside {8'h01, 8'h02, 8'h06, 8'hC7} |-> !serial_out_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("drive in write");
   property p_rd_hdr;
      @(posedge sclk) disable iff (cs_n)
         op_q == flash_pkg::OP_READ && cnt_q < 12'h0020 |-> !serial_out_oe;
   endproperty
   a_rd_hdr: assert property (p_rd_hdr) else $error("early read");
   property p_fr_hdr;
      @(posedge sclk) disable iff (cs_n)
         op_q == flash_pkg::OP_FAST_READ && cnt_q < 12'h0028
         |-> !serial_out_oe;
   endproperty
   a_fr_hdr: assert property (p_fr_hdr) else $error("early fast");
   property p_rd_hold;
      @(posedge sclk) disable iff (cs_n)
         (op_q == flash_pkg::OP_READ && cnt_q >= 12'h0021) ||
         (op_q == flash_pkg::OP_FAST_READ && cnt_q >= 12'h0029)
         |-> $stable(serial_out_oe);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("oe moved");
endmodule
bind flash_status_seq flash_status_seq_props flash_status_seq_props_i (
   .clk_sys(clk_sys),
   .rst(rst),
   .sclk(sclk),
   .cs_n(cs_n),
   .serial_in(serial_in),
   .wp_n(wp_n),
   .serial_out(serial_out),
   .serial_out_oe(serial_out_oe)
);

// >>> bench/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
   input wire logic clk_link,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   output logic sclk,
   output logic cs_n,
   output logic serial_in,
   output logic [7:0] rx_byte,
   output logic [15:0] rx_cnt,
   output logic oe_seen
);
   logic run;
   logic last;
   wire dout = serial_out_oe ? serial_out : ~last;
   // clock stands still outside frames
   assign sclk = clk_link & run;
   initial begin
      run = 1'b0;
      cs_n <= 1'b1;
      serial_in = 1'b0;
      last = 1'b0;
      rx_cnt = '0;
      oe_seen = 1'b0;
   end
   // released line toggles
   always @(posedge clk_link) last <= dout;
   // header bytes, then ncap captured bytes
   task automatic frame(input logic [7:0] q[$], input int ncap);
      logic [7:0] b;
      logic [7:0] rx;
      int n;
      n = q.size() + ncap;
      oe_seen = 1'b0;
      @(negedge clk_link);
      cs_n <= 1'b0;
      for (int k = 0; k < n; k++) begin
         b = (k < q.size()) ? q[k] : 8'h00;
         for (int i = 7; i >= 0; i--) begin
            @(negedge clk_link);
            serial_in <= b[i];
            run <= 1'b1;
            @(posedge clk_link);
            rx[i] = dout;
            oe_seen = oe_seen | serial_out_oe;
         end
         if (k >= q.size()) begin
            rx_byte = rx;
            rx_cnt <= rx_cnt + 16'h0001;
         end
      end
      @(negedge clk_link);
      run <= 1'b0;
      @(negedge clk_link);
      cs_n <= 1'b1;
      serial_in <= ~serial_in;
   endtask
endmodule

// >>> bench/serial_flash_status_read_program_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin \
   num_checks++; \
   if ((a) !== (b)) begin \
      n_errors++; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
   end \
end
module serial_flash_status_read_program_tb_top;
   logic clk_sys = 1'b0;
   logic clk_link = 1'b0;
   logic rst = 1'b0;
   logic wp_n = 1'b1;
   logic sclk, cs_n, serial_in, serial_out, serial_out_oe, oe_seen;
   logic [7:0] rx_byte;
   logic [15:0] rx_cnt;
   logic [15:0] note;
   logic [15:0] exq[$];
   logic [7:0] d[262];
   logic [15:0] lf = 16'hF3B3;
   int n_errors = 0;
   int num_checks = 0;
   initial forever #50 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #16 clk_link = ~clk_link;
   end
   flash_status_seq #(.ARR_AW(12)) flash_status_seq_i (
      .clk_sys(clk_sys),
      .rst(rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .serial_in(serial_in),
      .wp_n(wp_n),
      .serial_out(serial_out),
      .serial_out_oe(serial_out_oe)
   );
   spi_host_model spi_host_model_i (
      .clk_link(clk_link),
      .serial_out(serial_out),
      .serial_out_oe(serial_out_oe),
      .sclk(sclk),
      .cs_n(cs_n),
      .serial_in(serial_in),
      .rx_byte(rx_byte),
      .rx_cnt(rx_cnt),
      .oe_seen(oe_seen)
   );
   ////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic results;
      if (exq.size() != 0) n_errors++;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic op(input logic [7:0] q[$], input int ncap);
      spi_host_model_i.frame(q, ncap);
      wt(5);
   endtask
   task automatic stat(input logic [7:0] e, input logic [7:0] m);
      exq.push_back({m, e});
      op({flash_pkg::OP_READ_STATUS}, 1);
   endtask
   task automatic rd(input logic [23:0] a, input logic f,
                     input logic [7:0] e[$]);
      foreach (e[i]) exq.push_back({8'hFF, e[i]});
      if (f) op({flash_pkg::OP_FAST_READ, a[23:16], a[15:8], a[7:0],
                 8'h00}, e.size());
      else op({flash_pkg::OP_READ, a[23:16], a[15:8], a[7:0]}, e.size());
   endtask
   task automatic write_unlock_instr;
      op({flash_pkg::OP_WRITE_UNLOCK}, 0);
   endtask
   task automatic write_status_instr(input logic [7:0] v);
      write_unlock_instr();
      op({flash_pkg::OP_WRITE_STATUS, v}, 0);
   endtask
   task automatic pp(input logic [23:0] a, input int s, input int n);
      logic [7:0] q[$];
      q = {flash_pkg::OP_PAGE_WRITE, a[23:16], a[15:8], a[7:0]};
      for (int i = 0; i < n; i++) q.push_back(d[s + i]);
      write_unlock_instr();
      op(q, 0);
   endtask
   // oldest note against each captured byte
   always @(rx_cnt) begin
      if (rx_cnt !== 16'h0000) begin
         if (exq.size() == 0) begin
            n_errors++;
            $display("[FAIL] %0t unexpected byte", $time);
         end else begin
            note = exq.pop_front();
            `CHK(rx_byte & note[15:8], note[7:0])
         end
      end
   end
   // hang guard
   initial begin
      #2000000;
      n_errors++;
      results();
   end
   // main sequence
   initial begin
      rst <= 1'b1;
      for (int i = 0; i < 262; i++) begin
         lf = lfsr(lf);
         d[i] = lf[7:0];
      end
      wt(6);
      rst <= 1'b0;
      wt(5);
      exq.push_back(16'hFF00);
      exq.push_back(16'hFF00);
      op({flash_pkg::OP_READ_STATUS}, 2);
      op({flash_pkg::OP_WRITE_STATUS, 8'h1C}, 0);
      stat(8'h00, 8'hFF);
      write_unlock_instr();
      stat(8'h02, 8'hFF);
      op({flash_pkg::OP_WRITE_STATUS, 8'h1C, 8'h00}, 0);
      stat(8'h00, 8'h1D);
      pp(24'h000FFE, 258, 4);
      stat(8'h01, 8'hFF);
      exq.push_back(16'h0000);
      op({flash_pkg::OP_READ, 8'h00, 8'h00, 8'h00}, 1);
      `CHK(oe_seen, 1'b0)
      wt(160);
      rd(24'h000FFD, 0, {8'hFF, d[258], d[259]});
      rd(24'h000F00, 0, {d[260], d[261], 8'hFF});
      pp(24'h0000F0, 0, 258);
      wt(160);
      rd(24'hFFFFFF, 1, {d[259], d[16], d[17]});
      rd(24'h0000F0, 0, {d[256], d[257], d[2]});
      write_status_instr(8'h67);
      stat(8'h03, 8'hFF);
      wt(110);
      stat(8'h04, 8'hFF);
      pp(24'hFFFF00, 0, 1);
      stat(8'h00, 8'h01);
      rd(24'hFFFF00, 0, {d[260]});
      write_unlock_instr();
      op({flash_pkg::OP_WHOLE_WIPE}, 0);
      stat(8'h00, 8'h01);
      write_status_instr(8'h80);
      wt(110);
      wp_n <= 1'b0;
      wt(5);
      write_status_instr(8'h1C);
      stat(8'h80, 8'hFD);
      wp_n <= 1'b1;
      wt(5);
      write_status_instr(8'h00);
      wt(110);
      stat(8'h00, 8'hFF);
      write_unlock_instr();
      op({flash_pkg::OP_WHOLE_WIPE}, 0);
      stat(8'h01, 8'h01);
      wt(510);
      rd(24'h000000, 0, {8'hFF});
      op({flash_pkg::OP_OTP_ENTER}, 0);
      write_status_instr(8'h1C);
      wt(110);
      stat(8'h80, 8'h9C);
      pp(24'h000000, 5, 1);
      stat(8'h00, 8'h01);
      results();
   end
endmodule
